// >>> rtl/vet_timing_ctrl.sv
// Operation
// - Vertical blanking from programmed lines or standard
// - Force-blank bit holds output at blanking
// - Phase reset mode selects subcarrier reset
// - Luma delayed zero to three clocks
// - Code zero gives interlaced fields
// - Codes one to three give non-interlaced fields
// - Caption encoding per field selection
// - Teletext inserted only while enabled
// - Caption line is value plus offset
// - Start code sets reference pulse leading edge
// - End code sets reference pulse trailing edge
// - Upper code bits packed in shared register
// - First active line is value plus offset
// - Reference pin polarity follows polarity bit
`default_nettype none
module vet_timing_ctrl
    import vet_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       line_length_select,
    input  wire logic       mode_60hz,
    input  wire logic       m_system,
    input  wire logic       secam_mode,
    input  wire logic [8:0] first_active_line,
    input  wire logic [8:0] last_active_line,
    input  wire logic       realtime_ctrl_enable,
    input  wire logic       realtime_ctrl_input,
    input  wire logic       ref_pin_out_en,
    input  wire logic       ref_pin_polarity,
    input  wire logic [7:0] luma_in,
    input  wire logic [7:0] chroma_in,
    output logic      [7:0] luma_out,
    output logic      [7:0] chroma_out,
    output logic            second_ref_pin_o,
    output logic            second_ref_pin_oe_n,
    output logic            sync_start,
    output logic            vblank,
    output logic            odd_field,
    output logic            phase_reset,
    output logic            caption_active,
    output logic            teletext_insert_enable
);
    vet_ctrl_t   ctrl_r,   ctrl_nxt;
    vet_capt_t   capt_r,   capt_nxt;
    vet_pulse_t  pulse_r,  pulse_nxt;
    logic [7:0]  rdata_r,  rdata_nxt;

    logic [10:0] pix_r,    pix_nxt;
    logic [8:0]  line_r,   line_nxt;
    logic        odd_r,    odd_nxt;
    logic [2:0]  fcnt_r,   fcnt_nxt;
    logic        lpar_r,   lpar_nxt;
    logic        ref_lvl_r, ref_lvl_nxt;
    logic        ref_pin_r, ref_pin_nxt;
    logic        vbl_r,    vbl_nxt;
    logic        phr_r,    phr_nxt;
    logic        cap_r,    cap_nxt;
    logic        sync_r,   sync_nxt;
    logic [2:0]  rtc_sync_r, rtc_sync_nxt;
    logic [7:0]  dly_r [3];
    logic [7:0]  dly_nxt [3];
    logic [7:0]  luma_r,   luma_nxt;
    logic [7:0]  chroma_r, chroma_nxt;

    logic [10:0] pix_max;
    logic [8:0]  field_lines;
    logic [8:0]  line_ofs;
    logic        line_end;
    logic        field_end;
    logic [8:0]  cap_line;
    logic [7:0]  luma_sel;

    // Register file; each offset decodes alone so others keep their data
    always_comb begin
        ctrl_nxt  = ctrl_r;
        capt_nxt  = capt_r;
        pulse_nxt = pulse_r;
        if (reg_wr) begin
            unique case (reg_addr)
                VET_ADDR_CTRL:  ctrl_nxt = vet_ctrl_t'(reg_wdata);
                VET_ADDR_CAPT:  capt_nxt = vet_capt_t'(reg_wdata);
                VET_ADDR_RS_LO: pulse_nxt.start[7:0] = reg_wdata;
                VET_ADDR_RE_LO: pulse_nxt.stop[7:0] = reg_wdata;
                VET_ADDR_R_HI: begin
                    // Reserved bits are not stored and read as zero
                    pulse_nxt.stop[10:8] =
                        reg_wdata[VET_HI_END_LSB +: 3];
                    pulse_nxt.start[10:8] =
                        reg_wdata[VET_HI_STA_LSB +: 3];
                end
                default: ;
            endcase
        end
        unique case (reg_addr)
            VET_ADDR_CTRL:  rdata_nxt = ctrl_r;
            VET_ADDR_CAPT:  rdata_nxt = capt_r;
            VET_ADDR_RS_LO: rdata_nxt = pulse_r.start[7:0];
            VET_ADDR_RE_LO: rdata_nxt = pulse_r.stop[7:0];
            VET_ADDR_R_HI:  rdata_nxt = {1'b0, pulse_r.stop[10:8],
                                         1'b0, pulse_r.start[10:8]};
            default:        rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_r  <= vet_ctrl_t'(VET_RST_CTRL);
            capt_r  <= vet_capt_t'(VET_RST_CAPT);
            pulse_r <= {VET_RST_R_HI, VET_RST_RS_LO,
                        VET_RST_R_HI, VET_RST_RE_LO};
            rdata_r <= 8'h00;
        end else begin
            ctrl_r  <= ctrl_nxt;
            capt_r  <= capt_nxt;
            pulse_r <= pulse_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Line and field timing
    always_comb begin
        // Codes beyond the last pixel never match, so the pulse stalls
        pix_max  = line_length_select ? VET_PIX_MAX_SHORT
                                      : VET_PIX_MAX_LONG;
        line_ofs = m_system ? VET_LINE_OFS_M : VET_LINE_OFS_STD;
        unique case (ctrl_r.field_length_sel)
            2'b00:   field_lines = mode_60hz
                ? (odd_r ? VET_LINES_60_LONG : VET_LINES_60_SHORT)
                : (odd_r ? VET_LINES_50_LONG : VET_LINES_50_SHORT);
            2'b01:   field_lines = mode_60hz ? VET_LINES_60_SHORT
                                             : VET_LINES_50_SHORT;
            default: field_lines = mode_60hz ? VET_LINES_60_LONG
                                             : VET_LINES_50_LONG;
        endcase
        line_end  = (pix_r == pix_max);
        field_end = line_end && (line_r >= field_lines);
        pix_nxt   = line_end ? 11'h000 : pix_r + 11'h001;
        line_nxt  = field_end ? 9'h001
                  : (line_end ? line_r + 9'h001 : line_r);
        // Interlace alternates parity; fixed lengths keep one field type
        odd_nxt   = (field_end && ctrl_r.field_length_sel == 2'b00)
                  ? ~odd_r : (ctrl_r.field_length_sel == 2'b00 ? odd_r
                                                                : 1'b1);
        fcnt_nxt  = field_end ? fcnt_r + 3'h1 : fcnt_r;
        lpar_nxt  = line_end ? ~lpar_r : lpar_r;
        sync_nxt  = (pix_r == VET_SYNC_POS);

        if (ctrl_r.std_vblank_force)
            vbl_nxt = mode_60hz
                ? (line_r < VET_STD_VBI_60 || line_r > VET_STD_LAST_60)
                : (line_r < VET_STD_VBI_50
                   || line_r > VET_STD_LAST_50);
        else
            vbl_nxt = (line_r < first_active_line + line_ofs)
                   || (line_r > last_active_line + line_ofs);

        // Both edges sit at raw pixel positions; sync slope is at 49h
        if (pix_r == pulse_r.start)
            ref_lvl_nxt = 1'b1;
        else if (pix_r == pulse_r.stop)
            ref_lvl_nxt = 1'b0;
        else
            ref_lvl_nxt = ref_lvl_r;
        ref_pin_nxt = ref_lvl_nxt ^ ref_pin_polarity;

        rtc_sync_nxt = {rtc_sync_r[1:0], realtime_ctrl_input};
        unique case (ctrl_r.subcarrier_phase_reset_mode)
            2'b00: phr_nxt = realtime_ctrl_enable
                   && rtc_sync_r[1] && !rtc_sync_r[2];
            2'b01: phr_nxt = line_end && (secam_mode || lpar_r);
            2'b10: phr_nxt = field_end && fcnt_r == 3'h7;
            2'b11: phr_nxt = field_end && fcnt_r[1:0] == 2'h3;
        endcase

        cap_line = {4'h0, capt_r.caption_line_sel} + line_ofs;
        cap_nxt  = (line_r == cap_line)
                && (odd_r ? capt_r.caption_field_enable[0]
                          : capt_r.caption_field_enable[1]);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pix_r      <= 11'h000;
            line_r     <= 9'h001;
            odd_r      <= 1'b1;
            fcnt_r     <= 3'h0;
            lpar_r     <= 1'b0;
            ref_lvl_r  <= 1'b0;
            ref_pin_r  <= 1'b0;
            vbl_r      <= 1'b1;
            phr_r      <= 1'b0;
            cap_r      <= 1'b0;
            sync_r     <= 1'b0;
            rtc_sync_r <= 3'h0;
        end else begin
            pix_r      <= pix_nxt;
            line_r     <= line_nxt;
            odd_r      <= odd_nxt;
            fcnt_r     <= fcnt_nxt;
            lpar_r     <= lpar_nxt;
            ref_lvl_r  <= ref_lvl_nxt;
            ref_pin_r  <= ref_pin_nxt;
            vbl_r      <= vbl_nxt;
            phr_r      <= phr_nxt;
            cap_r      <= cap_nxt;
            sync_r     <= sync_nxt;
            rtc_sync_r <= rtc_sync_nxt;
        end
    end

    // Video path; chroma gets one stage so the relative delay is exact
    always_comb begin
        dly_nxt[0] = luma_in;
        dly_nxt[1] = dly_r[0];
        dly_nxt[2] = dly_r[1];
        unique case (ctrl_r.luma_delay_sel)
            2'b00: luma_sel = luma_in;
            2'b01: luma_sel = dly_r[0];
            2'b10: luma_sel = dly_r[1];
            2'b11: luma_sel = dly_r[2];
        endcase
        if (ctrl_r.force_blank_level) begin
            luma_nxt   = VET_BLANK_LEVEL;
            chroma_nxt = 8'h00;
        end else begin
            luma_nxt   = luma_sel;
            chroma_nxt = chroma_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dly_r[0] <= 8'h00;
            dly_r[1] <= 8'h00;
            dly_r[2] <= 8'h00;
            luma_r   <= 8'h00;
            chroma_r <= 8'h00;
        end else begin
            dly_r    <= dly_nxt;
            luma_r   <= luma_nxt;
            chroma_r <= chroma_nxt;
        end
    end

    assign reg_rdata              = rdata_r;
    assign luma_out               = luma_r;
    assign chroma_out             = chroma_r;
    assign second_ref_pin_o       = ref_pin_r;
    assign second_ref_pin_oe_n    = ~ref_pin_out_en;
    assign sync_start             = sync_r;
    assign vblank                 = vbl_r;
    assign odd_field              = odd_r;
    assign phase_reset            = phr_r;
    assign caption_active         = cap_r;
    assign teletext_insert_enable = capt_r.teletext_insert_enable;
endmodule // vet_timing_ctrl
`default_nettype wire

// >>> rtl/vet_pkg.sv
`default_nettype none
package vet_pkg;
    // Register offsets on the serial control port
    localparam logic [7:0] VET_ADDR_CTRL   = 8'h6e;
    localparam logic [7:0] VET_ADDR_CAPT   = 8'h6f;
    localparam logic [7:0] VET_ADDR_RS_LO  = 8'h70;
    localparam logic [7:0] VET_ADDR_RE_LO  = 8'h71;
    localparam logic [7:0] VET_ADDR_R_HI   = 8'h72;
    // Reset values
    localparam logic [7:0] VET_RST_CTRL    = 8'h40;
    localparam logic [7:0] VET_RST_CAPT    = 8'h00;
    localparam logic [7:0] VET_RST_RS_LO   = 8'h00;
    localparam logic [7:0] VET_RST_RE_LO   = 8'h00;
    localparam logic [2:0] VET_RST_R_HI    = 3'h0;
    // Field positions in the shared upper-bits register
    localparam int VET_HI_END_LSB = 4;
    localparam int VET_HI_STA_LSB = 0;
    // Line and field timing, blanking level
    localparam logic [10:0] VET_PIX_MAX_SHORT = 11'h6b3;
    localparam logic [10:0] VET_PIX_MAX_LONG  = 11'h6bf;
    localparam logic [10:0] VET_SYNC_POS      = 11'h049;
    localparam logic [8:0]  VET_LINES_50_LONG  = 9'h139;
    localparam logic [8:0]  VET_LINES_50_SHORT = 9'h138;
    localparam logic [8:0]  VET_LINES_60_LONG  = 9'h107;
    localparam logic [8:0]  VET_LINES_60_SHORT = 9'h106;
    localparam logic [8:0]  VET_STD_VBI_50    = 9'h017;
    localparam logic [8:0]  VET_STD_VBI_60    = 9'h014;
    localparam logic [8:0]  VET_STD_LAST_50   = 9'h136;
    localparam logic [8:0]  VET_STD_LAST_60   = 9'h105;
    localparam logic [8:0]  VET_LINE_OFS_M    = 9'h004;
    localparam logic [8:0]  VET_LINE_OFS_STD  = 9'h001;
    localparam logic [7:0]  VET_BLANK_LEVEL   = 8'h10;

    typedef struct packed {
        logic       std_vblank_force;
        logic       force_blank_level;
        logic [1:0] subcarrier_phase_reset_mode;
        logic [1:0] luma_delay_sel;
        logic [1:0] field_length_sel;
    } vet_ctrl_t;

    typedef struct packed {
        logic [1:0] caption_field_enable;
        logic       teletext_insert_enable;
        logic [4:0] caption_line_sel;
    } vet_capt_t;

    typedef struct packed {
        logic [10:0] start;
        logic [10:0] stop;
    } vet_pulse_t;
endpackage
`default_nettype wire

// >>> testbench/vet_timing_ctrl_props.sv
`default_nettype none
module vet_timing_ctrl_props
    import vet_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] chroma_in,
    input wire logic [7:0] chroma_out,
    input wire logic [7:0] luma_out,
    input wire logic       ref_pin_out_en,
    input wire logic       second_ref_pin_oe_n,
    input wire logic       second_ref_pin_o,
    input wire logic       sync_start,
    input wire logic       vblank,
    input wire logic       phase_reset,
    input wire logic       caption_active,
    input wire logic       teletext_insert_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic blank_r;
    // Shadow of the force-blank bit; the video checks depend on the mode
    always_ff @(posedge core_clk) begin
        if (!nrst)
            blank_r <= VET_RST_CTRL[6];
        else if (reg_wr && reg_addr == VET_ADDR_CTRL)
            blank_r <= reg_wdata[6];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    chk_unmapped_zero: assert property (
        !($past(reg_addr) inside {[8'h6e:8'h72]}) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_hi_reserved: assert property (
        $past(reg_addr) == VET_ADDR_R_HI |-> !reg_rdata[7] && !reg_rdata[3])
        else $error("reserved bits read back set");
    chk_rst_outputs: assert property (
        !$past(nrst) |-> vblank && !caption_active && !second_ref_pin_o)
        else $error("outputs not at reset state");
    chk_tt_reset: assert property (
        !$past(nrst) |-> !teletext_insert_enable)
        else $error("teletext enabled after reset");
    chk_sync_pulse: assert property (
        sync_start |=> !sync_start [*8])
        else $error("sync pulse too long");
    chk_phase_pulse: assert property (
        phase_reset |=> !phase_reset)
        else $error("phase reset not a single pulse");
    chk_oe_follow: assert property (
        second_ref_pin_oe_n == !ref_pin_out_en)
        else $error("pin enable wrong");
    chk_chroma_pipe: assert property (
        $past(nrst) |-> chroma_out ==
            ($past(blank_r) ? 8'h00 : $past(chroma_in)))
        else $error("chroma path not one cycle");
    chk_blank_luma: assert property (
        $past(nrst) && $past(blank_r) |-> luma_out == VET_BLANK_LEVEL)
        else $error("luma not at blanking level");
    cover property (caption_active);
    cover property ($rose(second_ref_pin_o));
    cover property (phase_reset);
endmodule // vet_timing_ctrl_props
bind vet_timing_ctrl vet_timing_ctrl_props u_props (
    .core_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .chroma_in, .chroma_out, .luma_out,
    .ref_pin_out_en, .second_ref_pin_oe_n, .second_ref_pin_o, .sync_start,
    .vblank, .phase_reset, .caption_active, .teletext_insert_enable
);
`default_nettype wire

// >>> testbench/test_video_encoder_timing_control.sv
`default_nettype none
module test_video_encoder_timing_control
    import vet_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int due; int sel; logic [7:0] v;} vet_note_t;
    logic       core_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [7:0] luma_in = 8'h00, chroma_in = 8'h00;
    logic       line_length_select = 1'h0, mode_60hz = 1'h0;
    logic       m_system = 1'h0, secam_mode = 1'h0;
    logic       realtime_ctrl_enable = 1'h0, realtime_ctrl_input = 1'h0;
    logic       ref_pin_out_en = 1'h1, ref_pin_polarity = 1'h0;
    logic [8:0] first_active_line = 9'h000, last_active_line = 9'h100;
    logic [7:0] reg_rdata, luma_out, chroma_out;
    logic       second_ref_pin_o, second_ref_pin_oe_n, sync_start, vblank;
    logic       phase_reset, caption_active, teletext_insert_enable;
    logic       odd_field;
    int         cyc = 0, fail_count = 0, num_checks = 0, pulses = 0;
    vet_note_t  exp_q[$];
    string      nm[9] = '{"rdata", "luma", "pin", "ttx", "oe_n", "capt",
                          "phs", "vblk", "odd"};
    vet_timing_ctrl DUT (
        .core_clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .line_length_select, .mode_60hz, .m_system, .secam_mode,
        .first_active_line, .last_active_line, .realtime_ctrl_enable,
        .realtime_ctrl_input, .ref_pin_out_en, .ref_pin_polarity,
        .luma_in, .chroma_in, .luma_out, .chroma_out, .second_ref_pin_o,
        .second_ref_pin_oe_n, .sync_start, .vblank, .odd_field,
        .phase_reset, .caption_active, .teletext_insert_enable);
    always #5 core_clk = ~core_clk;
    // Ceiling is five times the caption wait limit and ten times the sync wait limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (phase_reset === 1'h1)
            pulses <= pulses + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    function automatic logic [7:0] seen(int sel);
        case (sel)
            0: return reg_rdata;
            1: return luma_out;
            2: return {7'h00, second_ref_pin_o};
            3: return {7'h00, teletext_insert_enable};
            4: return {7'h00, second_ref_pin_oe_n};
            5: return {7'h00, caption_active};
            6: return pulses[7:0];
            7: return {7'h00, vblank};
            default: return {7'h00, odd_field};
        endcase
    endfunction
    always @(negedge core_clk) begin
        while (exp_q.size() > 0 && exp_q[0].due <= cyc) begin
            num_checks++;
            if (seen(exp_q[0].sel) !== exp_q[0].v) begin
                fail_count++;
                $display("BAD %s exp %h seen %h", nm[exp_q[0].sel],
                         exp_q[0].v, seen(exp_q[0].sel));
            end
            void'(exp_q.pop_front());
        end
    end
    // Notes are pushed in due order; the monitor only looks at the head
    task automatic note(int dly, int sel, logic [7:0] v);
        exp_q.push_back('{cyc + dly, sel, v});
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'h0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] v);
        @(negedge core_clk);
        reg_addr = a;
        note(1, 0, v);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        logic [7:0] a[6];
        logic [7:0] d[6];
        int n;
        a = '{VET_ADDR_CTRL, VET_ADDR_CAPT, VET_ADDR_RS_LO, VET_ADDR_RE_LO,
              VET_ADDR_R_HI, 8'h73};
        d = '{VET_RST_CTRL, VET_RST_CAPT, VET_RST_RS_LO, VET_RST_RE_LO,
              {1'h0, VET_RST_R_HI, 1'h0, VET_RST_R_HI}, 8'h00};
        void'($urandom(66964));
        repeat (3) @(negedge core_clk);
        nrst = 1'h1;
        luma_in = 8'($urandom);
        for (int i = 0; i < 6; i++)
            rd(a[i], d[i]);
        note(1, 1, VET_BLANK_LEVEL);
        $display("reset values done");
        wr(VET_ADDR_CAPT, 8'h41);
        for (n = 0; n < 4000 && caption_active !== 1'h1; n++)
            @(negedge core_clk);
        note(1, 5, 8'h01);
        note(1, 7, 8'h00);
        note(1, 8, 8'h01);
        // Still on the caption line, which the standard interval blanks
        wr(VET_ADDR_CTRL, 8'hc0);
        note(1, 7, 8'h01);
        $display("caption and blanking done");
        // Upper code bits kept at five or less so both codes stay legal
        for (int i = 0; i < 6; i++)
            d[i] = (i == 4) ? 8'($urandom) & 8'h55 : 8'($urandom);
        for (int i = 0; i < 6; i++)
            wr(a[i], d[i]);
        d[5] = 8'h00;
        for (int i = 0; i < 6; i++)
            rd(a[i], d[i]);
        $display("readback done");
        for (int b = 1; b >= 0; b--) begin
            wr(VET_ADDR_CAPT, {2'h0, 1'(b), 5'h00});
            note(1, 3, 8'(b));
        end
        $display("teletext done");
        for (int k = 0; k < 4; k++) begin
            wr(VET_ADDR_CTRL, {4'h0, 2'(k), 2'h0});
            repeat (8) begin
                @(negedge core_clk);
                luma_in = 8'($urandom);
                chroma_in = 8'($urandom);
                note(1 + k, 1, luma_in);
            end
            repeat (5) @(negedge core_clk);
        end
        $display("luma done");
        wr(VET_ADDR_RS_LO, 8'h49);
        wr(VET_ADDR_RE_LO, 8'h60);
        wr(VET_ADDR_R_HI, 8'h00);
        for (int p = 0; p < 2; p++) begin
            ref_pin_polarity = 1'(p);
            for (n = 0; n < 2000 && sync_start !== 1'h1; n++)
                @(negedge core_clk);
            note(1, 2, 8'(1 - p));
            note(1, 4, 8'h00);
            // End code sits 23 pixels after the sync position
            note(22, 2, 8'(1 - p));
            note(23, 2, 8'(p));
            repeat (30) @(negedge core_clk);
        end
        $display("ref pulse done");
        for (int e = 0; e < 2; e++) begin
            realtime_ctrl_enable = 1'(e);
            repeat (4) @(negedge core_clk);
            n = pulses;
            realtime_ctrl_input = 1'h1;
            repeat (12) @(negedge core_clk);
            realtime_ctrl_input = 1'h0;
            note(1, 6, 8'(n + e));
        end
        $display("phase done");
        repeat (30) @(negedge core_clk);
        complete_run();
    end
endmodule // test_video_encoder_timing_control
`default_nettype wire
